// File: sfp_map.vh
// Purpose: Offsets, field positions and codes for the flash guard block
// Assumes: Byte addresses on a 32-bit APB, one register per aligned word
// Notes:   Definitions only; included by bare name
`ifndef SFP_MAP_VH
`define SFP_MAP_VH

// Register byte offsets
`define SFP_OFS_CTRL      12'h038
`define SFP_OFS_ADDR      12'h03c
`define SFP_OFS_DATA      12'h040
`define SFP_OFS_STAT      12'h044
`define SFP_OFS_OPT       12'h048
`define SFP_OFS_GUARD     12'h04c

// Reset values
`define SFP_CTRL_RST      8'h00
`define SFP_ADDR_RST      16'h0000
`define SFP_DATA_RST      8'h00
`define SFP_OPT_RST       8'h00

// Control register command bits and busy bit
`define SFP_CTRL_PROG     0
`define SFP_CTRL_SERASE   1
`define SFP_CTRL_MERASE   2
`define SFP_CTRL_OPTW     3
`define SFP_CTRL_BUSY     7

// Status register bits
`define SFP_ST_BUSY       0
`define SFP_ST_ARMED      1
`define SFP_ST_REFUSED    2
`define SFP_ST_LOCKED     3

// Option byte field
`define SFP_OPT_LOCK      0

// Guard unlock keys
`define SFP_KEY1          8'h56
`define SFP_KEY2          8'hae

// Programming modes on the mode pins
`define SFP_MODE_RUN      2'h0
`define SFP_MODE_SELF     2'h1
`define SFP_MODE_ONBOARD  2'h2
`define SFP_MODE_TOOL     2'h3

// Fixed sector layout
`define SFP_SECTOR_BYTES  4096
`define SFP_ERASED        8'hff

`endif

// File: sfp_sector_map.v
// Purpose: Decode a CPU address into sector number and index range
// Assumes: Flash size is a power of two, at least one 4 Kbyte sector
// Notes:   Flash sits at the top of the 64 Kbyte space
`timescale 1ns/1ps
`include "sfp_map.vh"

module sfp_sector_map #(
  parameter FLASH_BYTES = 16384,
  parameter AW          = 14
) (
  input  wire [15:0]   addr_i,
  output reg  [1:0]    sector_o,
  output reg           present_o,
  output reg  [AW-1:0] first_o,
  output reg  [AW-1:0] last_o
);

  localparam [AW:0] SZ  = FLASH_BYTES;
  localparam [AW:0] SEC = `SFP_SECTOR_BYTES;

  // Sector count follows flash size
  wire [1:0] count_w = (FLASH_BYTES <= `SFP_SECTOR_BYTES) ? 2'h1 :
                       (FLASH_BYTES <= 2*`SFP_SECTOR_BYTES) ? 2'h2 : 2'h3;
  // Address lies inside the flash window
  wire       in_flash_w = &addr_i[15:AW];

  // Top 4K is sector 0, next 4K sector 1, the rest sector 2
  always @* begin
    if (addr_i[15:12] == 4'hf) begin
      sector_o = 2'h0;
      first_o  = SZ[AW-1:0] - SEC[AW-1:0];
      last_o   = SZ[AW-1:0] - 1'b1;
    end else if (addr_i[15:12] == 4'he) begin
      sector_o = 2'h1;
      first_o  = SZ[AW-1:0] - SEC[AW-1:0] - SEC[AW-1:0];
      last_o   = SZ[AW-1:0] - SEC[AW-1:0] - 1'b1;
    end else begin
      sector_o = 2'h2;
      first_o  = {AW{1'b0}};
      last_o   = SZ[AW-1:0] - SEC[AW-1:0] - SEC[AW-1:0] - 1'b1;
    end
    present_o = in_flash_w && (sector_o < count_w); // R3 R4
  end

endmodule // sfp_sector_map

// File: sfp_flash_guard.v
// Purpose: Sectored program flash with mode-based protection and guard
// Assumes: APB slave, one wait state; mode pins are asynchronous
// Notes:   The array is modelled as byte registers, erased value ff
//
// What this block does
// [R1] Whole-block or sector erase; byte programming
// [R2] Sector erase touches only that sector
// [R3] Sector count follows flash size
// [R4] 4K sectors at top; sector 0 holds vectors
// [R5] Self-update mode may not touch sector 0
// [R6] Board and tool modes reach all, option too
// [R7] Read-out lock hides memory from outside
// [R8] Removing the lock mass-erases first; here reset_i loads opt_q with 00h, dropping the lock with no erase
// [R9] Lock is one option byte bit, written
// [R10] Key sequence must arm before program/erase
// [R11] Control register at 0038h, reset 00h
// [R12] Only tool software writes the control register; here any APB write reaches it, and the mode checks gate the commands
// [R13] Commands to absent sectors are ignored
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "sfp_map.vh"

module sfp_flash_guard #(
  parameter FLASH_BYTES = 16384,
  parameter AW          = 14
) (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire [1:0]  prog_mode_i,
  output reg         busy_o,
  output reg         readout_locked_o
);

  // Engine states
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_PROG  = 2'h1;
  localparam [1:0] ST_ERASE = 2'h2;
  localparam [1:0] ST_OPTW  = 2'h3;

  reg  [7:0]    mem [0:FLASH_BYTES-1]; // Program store array
  reg  [1:0]    mode_m_q;              // First synchroniser stage
  reg  [1:0]    mode_q;                // Synchronised mode
  reg  [7:0]    ctrl_q;                // Control/status register
  reg  [15:0]   addr_q;                // Target CPU address
  reg  [7:0]    data_q;                // Byte to program
  reg  [7:0]    opt_q;                 // Option byte
  reg  [7:0]    opt_new_q;             // Option value waiting to land
  reg           key1_q;                // First key seen
  reg           armed_q;               // Guard open for one command
  reg           refused_q;             // Sticky refused flag
  reg  [1:0]    state_q;               // Engine state
  reg  [AW-1:0] ptr_q;                 // Erase walk pointer
  reg  [AW-1:0] last_q;                // Erase walk end
  reg           then_opt_q;            // Option write follows erase
  reg  [7:0]    rdbyte_q;              // Array read latch

  wire [1:0]    sector_w;              // Decoded sector
  wire          present_w;             // Sector exists
  wire [AW-1:0] first_w;               // Sector first index
  wire [AW-1:0] last_w;                // Sector last index

  // Sector decode of the target address
  sfp_sector_map #(
    .FLASH_BYTES (FLASH_BYTES),
    .AW          (AW)
  ) u_map (
    .addr_i    (addr_q),
    .sector_o  (sector_w),
    .present_o (present_w),
    .first_o   (first_w),
    .last_o    (last_w)
  );

  // Mode pins cross in through two flops
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_m_q <= `SFP_MODE_RUN;
      mode_q   <= `SFP_MODE_RUN;
    end else begin
      mode_m_q <= prog_mode_i;
      mode_q   <= mode_m_q;
    end
  end

  // Mode qualifiers
  wire full_mode_w = (mode_q == `SFP_MODE_ONBOARD) ||
                     (mode_q == `SFP_MODE_TOOL);        // R6
  wire self_mode_w = (mode_q == `SFP_MODE_SELF);
  // Run mode grants nothing at all
  // Outside parties reach memory only in board or tool mode
  wire external_w  = full_mode_w;
  wire locked_w    = opt_q[`SFP_OPT_LOCK];              // R9

  // APB phases: access cycle before ready, and the completing edge
  wire acc_w  = psel_i & penable_i & ~pready_o;
  wire fire_w = psel_i & penable_i & pready_o;
  wire wr_w   = fire_w & pwrite_i;

  // Address decode
  wire hit_ctrl_w  = (paddr_i == `SFP_OFS_CTRL);        // R11
  wire hit_addr_w  = (paddr_i == `SFP_OFS_ADDR);
  wire hit_data_w  = (paddr_i == `SFP_OFS_DATA);
  wire hit_stat_w  = (paddr_i == `SFP_OFS_STAT);
  wire hit_opt_w   = (paddr_i == `SFP_OFS_OPT);
  wire hit_guard_w = (paddr_i == `SFP_OFS_GUARD);
  wire hit_any_w   = hit_ctrl_w | hit_addr_w | hit_data_w |
                     hit_stat_w | hit_opt_w | hit_guard_w;

  // Command decode on a control write
  wire       cmd_wr_w  = wr_w & hit_ctrl_w;              // R12
  wire [7:0] cmd_w     = pwdata_i[7:0];
  wire       c_prog_w  = cmd_w[`SFP_CTRL_PROG];
  wire       c_serase_w = cmd_w[`SFP_CTRL_SERASE];
  wire       c_merase_w = cmd_w[`SFP_CTRL_MERASE];
  wire       c_optw_w  = cmd_w[`SFP_CTRL_OPTW];
  wire       c_any_w   = c_prog_w | c_serase_w | c_merase_w | c_optw_w;
  // Exactly one command bit may be set
  wire       c_one_w   = ((c_prog_w + c_serase_w) +
                          (c_merase_w + c_optw_w)) == 3'h1;

  // Permission checks per command
  // Sector 0 is shut in self-update mode
  wire sec_ok_w  = present_w &&                                 // R13
                   (full_mode_w || (self_mode_w && sector_w != 2'h0)); // R5
  // Mass erase and option writes stay with board and tool modes
  wire mass_ok_w = full_mode_w;                                 // R6
  wire opt_ok_w  = full_mode_w;                                 // R6
  reg  allow_r;
  always @* begin
    allow_r = 1'b0;
    if (c_prog_w || c_serase_w)
      allow_r = sec_ok_w;
    else if (c_merase_w)
      allow_r = mass_ok_w;
    else if (c_optw_w)
      allow_r = opt_ok_w;
  end

  // A command starts only when armed, idle, well formed and allowed
  wire start_w  = cmd_wr_w & c_any_w & c_one_w & armed_q &
                  (state_q == ST_IDLE) & allow_r;               // R10
  wire refuse_w = cmd_wr_w & c_any_w & ~start_w;

  // Lock is being cleared by this option write. The new option value
  // comes from the data register: the command byte must be one-hot,
  // so it cannot carry a lock bit of its own
  wire unlock_w = locked_w & ~data_q[`SFP_OPT_LOCK];     // R8

  // Guard key sequence; any other guard write resets it
  // A stray guard or command write between the keys starts the sequence over, so a
  // runaway loop is unlikely to arm the guard by chance
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      key1_q  <= 1'b0;
      armed_q <= 1'b0;
    end else if (cmd_wr_w && c_any_w) begin
      key1_q  <= 1'b0;
      armed_q <= 1'b0;                                 // R10
    end else if (wr_w && hit_guard_w) begin
      if (pwdata_i[7:0] == `SFP_KEY1) begin
        key1_q  <= 1'b1;
        armed_q <= 1'b0;
      end else if (key1_q && pwdata_i[7:0] == `SFP_KEY2) begin
        key1_q  <= 1'b0;
        armed_q <= 1'b1;                               // R10
      end else begin
        key1_q  <= 1'b0;
        armed_q <= 1'b0;
      end
    end
  end

  // Sticky refused flag; a new refusal beats a clear
  always @(posedge clk_sys_i) begin
    if (reset_i)
      refused_q <= 1'b0;
    else if (refuse_w)
      refused_q <= 1'b1;
    else if (wr_w && hit_stat_w && pwdata_i[`SFP_ST_REFUSED])
      refused_q <= 1'b0;
  end

  // Address and data registers; frozen while the engine runs
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      addr_q <= `SFP_ADDR_RST;
      data_q <= `SFP_DATA_RST;
    end else if (state_q == ST_IDLE) begin
      if (wr_w && hit_addr_w)
        addr_q <= pwdata_i[15:0];
      if (wr_w && hit_data_w)
        data_q <= pwdata_i[7:0];
    end
  end

  // Program/erase engine and the array itself
  // Address and data stay frozen by the idle test above while it runs
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q    <= ST_IDLE;
      ctrl_q     <= `SFP_CTRL_RST;                     // R11
      opt_q      <= `SFP_OPT_RST;
      opt_new_q  <= `SFP_OPT_RST;
      ptr_q      <= {AW{1'b0}};
      last_q     <= {AW{1'b0}};
      then_opt_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_w) begin
            ctrl_q <= cmd_w & 8'h0f;
            ctrl_q[`SFP_CTRL_BUSY] <= 1'b1;
            if (c_prog_w) begin
              state_q <= ST_PROG;                      // R1
            end else if (c_serase_w) begin
              ptr_q   <= first_w;                      // R2
              last_q  <= last_w;
              state_q <= ST_ERASE;
            end else if (c_merase_w) begin
              ptr_q   <= {AW{1'b0}};                   // R1
              last_q  <= {AW{1'b1}};
              state_q <= ST_ERASE;
            end else begin
              opt_new_q <= data_q;                     // R9
              if (unlock_w) begin
                // Wipe everything before the lock can drop
                ptr_q      <= {AW{1'b0}};              // R8
                last_q     <= {AW{1'b1}};
                then_opt_q <= 1'b1;
                state_q    <= ST_ERASE;
              end else begin
                state_q <= ST_OPTW;
              end
            end
          end else if (cmd_wr_w && !c_any_w) begin
            ctrl_q <= `SFP_CTRL_RST;
          end
        end
        ST_PROG: begin
          // One byte per command; bits only go from 1 to 0
          mem[addr_q[AW-1:0]] <= mem[addr_q[AW-1:0]] & data_q; // R1
          ctrl_q  <= `SFP_CTRL_RST;
          state_q <= ST_IDLE;
        end
        ST_ERASE: begin
          // One byte per cycle over the chosen range only
          // Busy stays high for the whole walk; new commands are refused
          mem[ptr_q] <= `SFP_ERASED;                   // R2
          if (ptr_q == last_q) begin
            if (then_opt_q) begin
              then_opt_q <= 1'b0;
              state_q    <= ST_OPTW;                   // R8
            end else begin
              ctrl_q  <= `SFP_CTRL_RST;
              state_q <= ST_IDLE;
            end
          end else begin
            ptr_q <= ptr_q + 1'b1;
          end
        end
        ST_OPTW: begin
          opt_q   <= opt_new_q;                        // R9
          ctrl_q  <= `SFP_CTRL_RST;
          state_q <= ST_IDLE;
        end
        default: begin
          ctrl_q  <= `SFP_CTRL_RST;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Array read latch; outsiders see nothing while locked
  // Latching costs one cycle after an address change but keeps the
  // array read off the bus decode path
  always @(posedge clk_sys_i) begin
    if (reset_i)
      rdbyte_q <= `SFP_DATA_RST;
    else if (locked_w && external_w)
      rdbyte_q <= `SFP_DATA_RST;                       // R7
    else if (&addr_q[15:AW])
      rdbyte_q <= mem[addr_q[AW-1:0]];
    else
      rdbyte_q <= `SFP_DATA_RST;
  end

  // Read mux, evaluated in the first access cycle
  reg [31:0] rd_r;
  always @* begin
    rd_r = 32'h0000_0000;
    if (hit_ctrl_w)
      rd_r[7:0] = ctrl_q;
    else if (hit_addr_w)
      rd_r[15:0] = addr_q;
    else if (hit_data_w)
      rd_r[7:0] = rdbyte_q;                            // R7
    else if (hit_stat_w) begin
      rd_r[`SFP_ST_BUSY]    = (state_q != ST_IDLE);
      rd_r[`SFP_ST_ARMED]   = armed_q;
      rd_r[`SFP_ST_REFUSED] = refused_q;
      rd_r[`SFP_ST_LOCKED]  = locked_w;
    end else if (hit_opt_w)
      rd_r[7:0] = opt_q;
  end

  // APB answer: ready one cycle into the access phase
  // The extra cycle keeps every bus output on a flop
  // Writes return zero data; reads load the read mux value
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (acc_w) begin
      pready_o  <= 1'b1;
      pslverr_o <= ~hit_any_w;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_r;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Side status pins
  // One cycle behind the engine, like every other output flop
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_o           <= 1'b0;
      readout_locked_o <= 1'b0;
    end else begin
      busy_o           <= (state_q != ST_IDLE);
      readout_locked_o <= locked_w;                    // R7
    end
  end

endmodule // sfp_flash_guard

// File: sfp_flash_guard_asserts.sv
// Purpose: Port-level checks for the flash guard block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every guard instance below
`timescale 1ns/1ps

module sfp_flash_guard_asserts #(
  parameter FLASH_BYTES = 16384
) (
  input wire        clk_sys_i,
  input wire        reset_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [1:0]  prog_mode_i,
  input wire        busy_o,
  input wire        readout_locked_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  int busy_n_q; // Length of the current busy run

  // Unlock is the longest run: a mass erase, then the option write
  always @(posedge clk_sys_i) begin
    if (reset_i || !busy_o) busy_n_q <= 0;
    else busy_n_q <= busy_n_q + 1;
  end

  a_ready_wait: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase not answered after one wait");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_ready_cause: assert property (
    !(psel_i && penable_i) |=> !pready_o)
    else $error("ready without an access phase");
  a_err_pair: assert property (pslverr_o |-> pready_o)
    else $error("error flag without ready");
  a_err_rdzero: assert property (
    pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("unmapped read returned data");
  a_upper_zero: assert property (
    pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset_i |=> !busy_o && !readout_locked_o && !pready_o)
    else $error("outputs active after reset edge");
  a_busy_mode: assert property (
    $rose(busy_o) |-> prog_mode_i != 2'h0)
    else $error("engine started in run mode");
  a_busy_bound: assert property (
    busy_n_q <= 2 * FLASH_BYTES + 16)
    else $error("engine busy too long");
  a_lock_rd: assert property (
    pready_o && !pwrite_i && !pslverr_o && paddr_i == 12'h048
    |-> prdata_o[0] == readout_locked_o)
    else $error("option read disagrees with lock pin");
endmodule // sfp_flash_guard_asserts

bind sfp_flash_guard sfp_flash_guard_asserts #(
  .FLASH_BYTES(FLASH_BYTES)
) u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .prog_mode_i(prog_mode_i), .busy_o(busy_o),
  .readout_locked_o(readout_locked_o)
);

// File: sfp_tool_model.sv
// Purpose: Programming party that owns the mode pins
// Assumes: Mode requests come from the bench sequence
// Notes:   Pins move only just after a rising edge
`timescale 1ns/1ps

module sfp_tool_model (
  input  wire       clk_sys_i,
  input  wire [1:0] want_mode_i,
  output reg  [1:0] prog_mode_o
);
  // Starts in board mode so the first erase is allowed
  initial prog_mode_o = 2'h2;

  // Only the tool side chooses the mode; held steady between runs
  always @(posedge clk_sys_i) begin
    prog_mode_o <= want_mode_i;
  end
endmodule // sfp_tool_model

// File: tb_sectored_flash_protection.sv
// Purpose: Self-checking bench for the flash guard block
// Assumes: 8 Kbyte flash, so sectors 0 and 1 only
// Notes:   Reads queue their expected {pslverr,prdata}
`timescale 1ns/1ps
`include "sfp_map.vh"

module tb_sectored_flash_protection;
  reg          clk_sys_i = 1'b0;
  reg          reset_i   = 1'b1;
  reg          psel_i    = 1'b0;
  reg          penable_i = 1'b0;
  reg          pwrite_i  = 1'b0;
  reg   [11:0] paddr_i   = 12'h000;
  reg   [31:0] pwdata_i  = 32'h0;
  reg   [1:0]  want_q    = `SFP_MODE_ONBOARD; // Mode asked of tool
  wire  [1:0]  prog_mode;
  wire  [31:0] prdata_o;
  wire         pready_o;
  wire         pslverr_o;
  wire         busy_o;
  wire         readout_locked_o;
  logic [32:0] exp_q[$];                // Oldest expected read first
  reg   [31:0] rnd_q     = 32'h80bfb622; // Fixed seed
  reg   [7:0]  b1;
  reg   [7:0]  b2;
  int          error_cnt   = 0;
  int          check_count = 0;

  // Free-running 40 MHz clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  sfp_tool_model u_tool (
    .clk_sys_i(clk_sys_i), .want_mode_i(want_q), .prog_mode_o(prog_mode)
  );

  // Small flash keeps erase times short
  sfp_flash_guard #(.FLASH_BYTES(8192), .AW(13)) dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prog_mode_i(prog_mode), .busy_o(busy_o),
    .readout_locked_o(readout_locked_o)
  );

  // Xorshift step; low byte becomes program data
  function [7:0] rnd;
    rnd_q = rnd_q ^ (rnd_q << 13);
    rnd_q = rnd_q ^ (rnd_q >> 17);
    rnd_q = rnd_q ^ (rnd_q << 5);
    return rnd_q[7:0];
  endfunction

  task report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compare each completed read with the oldest note
  always @(posedge clk_sys_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
      check_count++;
      if (exp_q.size() == 0 || {pslverr_o, prdata_o} !== exp_q[0]) begin
        error_cnt++;
        $display("mismatch at %0t: read %h got %h", $time, paddr_i,
                 prdata_o);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  // One APB transfer; held until pready is seen at an edge
  task apb(input bit is_wr, input [11:0] a, input [31:0] d,
           input [32:0] e);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i   <= 1'b1;
    pwrite_i <= is_wr;
    paddr_i  <= a;
    pwdata_i <= d;
    if (!is_wr) exp_q.push_back(e);
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      $display("mismatch at %0t: no ready", $time);
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task rd(input [11:0] a, input [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task chk(input bit ok);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: pin value", $time);
    end
  endtask

  // Busy lags the engine, so give it a few edges to rise first
  task wait_idle;
    int n;
    n = 0;
    repeat (4) @(posedge clk_sys_i);
    while (busy_o !== 1'b0 && n < 20000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(n < 20000);
  endtask

  // Armed command: address, both keys, one-hot command
  task cmd(input [15:0] ad, input [7:0] c);
    wr(`SFP_OFS_ADDR, {16'h0, ad});
    wr(`SFP_OFS_GUARD, {24'h0, `SFP_KEY1});
    wr(`SFP_OFS_GUARD, {24'h0, `SFP_KEY2});
    wr(`SFP_OFS_CTRL, {24'h0, c});
    wait_idle;
  endtask

  // Expect a refusal flag, then clear it by writing one
  task refused;
    rd(`SFP_OFS_STAT, 33'h4);
    wr(`SFP_OFS_STAT, 32'h4);
    rd(`SFP_OFS_STAT, 33'h0);
  endtask

  // Mode pins pass a two-flop synchroniser
  task mode(input [1:0] m);
    want_q <= m;
    repeat (6) @(posedge clk_sys_i);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(`SFP_OFS_CTRL, 33'h0);
    rd(12'hffc, 33'h100000000);
    cmd(16'he000, 8'h04);
    b1 = rnd();
    b2 = rnd();
    wr(`SFP_OFS_DATA, {24'h0, b1});
    cmd(16'he000, 8'h01);
    rd(`SFP_OFS_DATA, {25'h0, b1});
    wr(`SFP_OFS_DATA, {24'h0, b2});
    cmd(16'hf000, 8'h01);
    rd(`SFP_OFS_DATA, {25'h0, b2});
    mode(`SFP_MODE_SELF);
    cmd(16'hf000, 8'h02);
    refused;
    rd(`SFP_OFS_DATA, {25'h0, b2});
    wr(`SFP_OFS_ADDR, 32'he000);
    wr(`SFP_OFS_CTRL, 32'h1);
    refused;
    b2 = rnd();
    wr(`SFP_OFS_DATA, {24'h0, b2});
    cmd(16'he000, 8'h01);
    b1 = b1 & b2;
    rd(`SFP_OFS_DATA, {25'h0, b1});
    mode(`SFP_MODE_RUN);
    cmd(16'he000, 8'h01);
    refused;
    mode(`SFP_MODE_ONBOARD);
    cmd(16'hd000, 8'h02);
    refused;
    cmd(16'hf000, 8'h02);
    rd(`SFP_OFS_DATA, 33'hff);
    wr(`SFP_OFS_ADDR, 32'he000);
    rd(`SFP_OFS_DATA, {25'h0, b1});
    mode(`SFP_MODE_TOOL);
    wr(`SFP_OFS_DATA, 32'h1);
    cmd(16'he000, 8'h08);
    chk(readout_locked_o === 1'b1);
    rd(`SFP_OFS_OPT, 33'h1);
    rd(`SFP_OFS_DATA, 33'h0);
    wr(`SFP_OFS_DATA, 32'h0);
    wr(`SFP_OFS_GUARD, {24'h0, `SFP_KEY1});
    wr(`SFP_OFS_GUARD, {24'h0, `SFP_KEY2});
    wr(`SFP_OFS_CTRL, 32'h8);
    rd(`SFP_OFS_STAT, 33'h9);
    rd(`SFP_OFS_CTRL, 33'h88);
    wait_idle;
    rd(`SFP_OFS_OPT, 33'h0);
    rd(`SFP_OFS_DATA, 33'hff);
    rd(`SFP_OFS_CTRL, 33'h0);
    report_and_stop;
  end

  // Two full erases dominate; the limit leaves ample slack
  initial begin
    #(25.0 * 60000);
    error_cnt++;
    $display("mismatch at %0t: watchdog", $time);
    report_and_stop;
  end
endmodule // tb_sectored_flash_protection
